// ==== include/rmde_cfg.svh ====
// constants of the register move decode and execute block
// included by the package and every design file; definitions only
`ifndef RMDE_CFG_SVH
`define RMDE_CFG_SVH

// instruction fields
`define RMDE_F_MAJOR 31:26
`define RMDE_F_SUB 25:21
`define RMDE_F_TGT 20:16
`define RMDE_F_SRCG 25:21
`define RMDE_F_DSTG 15:11
`define RMDE_F_FSRC 15:11
`define RMDE_F_FDST 10:6
`define RMDE_F_FUNC 5:0
`define RMDE_F_CCSEL 20:18
`define RMDE_F_TFZ 17:16
`define RMDE_F_IMPL 15:0
`define RMDE_F_CPRD 15:11
`define RMDE_F_SEL 2:0
`define RMDE_F_Z8 10:3
`define RMDE_F_Z11 10:0
`define RMDE_F_Z10 25:16
`define RMDE_F_FMT 25:21

// opcodes and sub-codes
`define RMDE_OP_SPECIAL 6'h00
`define RMDE_OP_SYSCP 6'h10
`define RMDE_OP_FPU 6'h11
`define RMDE_OP_CP2 6'h12
`define RMDE_SUB_MF 5'h00
`define RMDE_SUB_MFH0 5'h02
`define RMDE_SUB_MFH 5'h03
`define RMDE_FN_UPPER 6'h10
`define RMDE_FN_BOTTOM 6'h12
`define RMDE_FN_CONDMV 6'h01
`define RMDE_FN_NZ 6'h0b
`define RMDE_FN_FCOPY 6'h06
`define RMDE_FN_FCMOV 6'h11
`define RMDE_FMT_PAIR 5'h16
`define RMDE_REL2 3'h2

// register offsets
`define RMDE_OFF_CTRL 8'h00
`define RMDE_OFF_INSTR 8'h04
`define RMDE_OFF_STATUS 8'h08
`define RMDE_OFF_RES_LOWER 8'h0c
`define RMDE_OFF_RES_UPPER 8'h10

// control and status bits
`define RMDE_CTRL_WIDE_MODE 0
`define RMDE_CTRL_FPU64 1
`define RMDE_CTRL_CU0 2
`define RMDE_CTRL_CU1 3
`define RMDE_CTRL_CU2 4
`define RMDE_CTRL_REL 10:8
`define RMDE_CTRL_RST 32'h0000_021c
`define RMDE_ST_BUSY 0
`define RMDE_ST_DONE 1
`define RMDE_ST_EXC 2
`define RMDE_ST_CODE 4:3
`define RMDE_ST_UNDEF 5
`define RMDE_ST_WROTE 6

// bus responses
`define RMDE_RESP_OKAY 2'h0
`define RMDE_RESP_SLVERR 2'h2
`endif

// ==== include/rmde_pkg.sv ====
// types of the register move decode and execute block
// includes rmde_cfg.svh but writes its own type widths out as literals
package rmde_pkg;
`include "rmde_cfg.svh"
	typedef enum logic [1:0] {RMDE_IDLE, RMDE_READ, RMDE_EXEC} rmde_state_type;
	typedef enum logic [1:0] {RMDE_EXC_NONE, RMDE_EXC_RI, RMDE_EXC_CPU}
		rmde_exc_type;
	typedef enum logic [3:0] {RMDE_OP_BAD, RMDE_OP_CP2_WORD, RMDE_OP_SYS_HIGH,
		RMDE_OP_FREG_HIGH, RMDE_OP_CP2_HIGH, RMDE_OP_UPPER, RMDE_OP_BOTTOM,
		RMDE_OP_FCOPY, RMDE_OP_GCMOVF, RMDE_OP_FCMOVF, RMDE_OP_NZ}
		rmde_op_type;
	typedef struct packed {
		rmde_op_type op;
		logic [4:0] dst;
		logic [4:0] src_a;
		logic [4:0] src_b;
		logic [15:0] cp_sel;
		logic [2:0] cond;
		logic [4:0] fmt;
	} rmde_dec_type;
	typedef struct packed {
		logic aw_have;
		logic [7:0] awaddr;
		logic w_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} rmde_bus_type;
	typedef struct packed {
		rmde_state_type state;
		logic [31:0] ctrl;
		logic [31:0] instr;
		logic done;
		logic exc_flag;
		rmde_exc_type exc_code;
		logic undef;
		logic wrote;
		logic [31:0] res_lower;
		logic [31:0] res_upper;
		logic greg_we;
		logic [4:0] greg_waddr;
		logic [31:0] greg_wdata;
		logic freg_we;
		logic [4:0] freg_waddr;
		logic [63:0] freg_wdata;
		logic exc_pulse;
	} rmde_core_type;
endpackage

// ==== rtl/rmde_decode.sv ====
// instruction decoder of the register move block
// purely combinational; the caller holds the instruction word stable
`timescale 1ns/1ps
`include "rmde_cfg.svh"
module rmde_decode
	import rmde_pkg::*;
(
	// instruction in
	input wire logic [31:0] instr,
	// decoded fields out
	output rmde_dec_type dec
);
	always_comb
	begin
		dec = '0;
		dec.op = RMDE_OP_BAD;
		dec.cp_sel = instr[`RMDE_F_IMPL];
		dec.cond = instr[`RMDE_F_CCSEL];
		dec.fmt = instr[`RMDE_F_FMT];
		unique case (instr[`RMDE_F_MAJOR])
			`RMDE_OP_SPECIAL:
			begin
				dec.dst = instr[`RMDE_F_DSTG];
				dec.src_a = instr[`RMDE_F_SRCG];
				dec.src_b = instr[`RMDE_F_TGT];
				if (instr[`RMDE_F_FUNC] == `RMDE_FN_UPPER && instr[`RMDE_F_Z10] == '0)
					dec.op = RMDE_OP_UPPER;
				else if (instr[`RMDE_F_FUNC] == `RMDE_FN_BOTTOM)
					dec.op = RMDE_OP_BOTTOM;
				else if (instr[`RMDE_F_FUNC] == `RMDE_FN_CONDMV &&
					instr[`RMDE_F_TFZ] == '0)
					dec.op = RMDE_OP_GCMOVF;
				else if (instr[`RMDE_F_FUNC] == `RMDE_FN_NZ)
					dec.op = RMDE_OP_NZ;
			end
			`RMDE_OP_SYSCP:
			begin
				dec.dst = instr[`RMDE_F_TGT];
				if (instr[`RMDE_F_SUB] == `RMDE_SUB_MFH0 && instr[`RMDE_F_Z8] == '0)
					dec.op = RMDE_OP_SYS_HIGH;
			end
			`RMDE_OP_FPU:
			begin
				dec.src_a = instr[`RMDE_F_FSRC];
				dec.src_b = instr[`RMDE_F_FDST];
				if (instr[`RMDE_F_SUB] == `RMDE_SUB_MFH && instr[`RMDE_F_Z11] == '0)
				begin
					dec.op = RMDE_OP_FREG_HIGH;
					dec.dst = instr[`RMDE_F_TGT];
				end
				else if (instr[`RMDE_F_FUNC] == `RMDE_FN_FCOPY &&
					instr[`RMDE_F_TGT] == '0)
				begin
					dec.op = RMDE_OP_FCOPY;
					dec.dst = instr[`RMDE_F_FDST];
				end
				else if (instr[`RMDE_F_FUNC] == `RMDE_FN_FCMOV &&
					instr[`RMDE_F_TFZ] == '0)
				begin
					dec.op = RMDE_OP_FCMOVF;
					dec.dst = instr[`RMDE_F_FDST];
				end
			end
			`RMDE_OP_CP2:
			begin
				dec.dst = instr[`RMDE_F_TGT];
				if (instr[`RMDE_F_SUB] == `RMDE_SUB_MF)
					dec.op = RMDE_OP_CP2_WORD;
				else if (instr[`RMDE_F_SUB] == `RMDE_SUB_MFH)
					dec.op = RMDE_OP_CP2_HIGH;
			end
			default:
			begin
				dec.op = RMDE_OP_BAD;
			end
		endcase
	end
endmodule

// ==== rtl/rmde_axil.sv ====
// axi4-lite slave front end of the register move block
// the owner decodes addresses and answers reads in the same cycle
`timescale 1ns/1ps
`include "rmde_cfg.svh"
module rmde_axil
	import rmde_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// register side
	output logic reg_wr_en,
	output logic [7:0] reg_wr_addr,
	output logic [31:0] reg_wr_data,
	output logic [3:0] reg_wr_strb,
	input wire logic reg_wr_ok,
	output logic [7:0] reg_rd_addr,
	input wire logic [31:0] reg_rd_data,
	input wire logic reg_rd_ok
);
	rmde_bus_type bus_reg;
	rmde_bus_type bus_next;

	assign s_axi_awready = !bus_reg.aw_have && !bus_reg.bvalid;
	assign s_axi_wready = !bus_reg.w_have && !bus_reg.bvalid;
	assign s_axi_arready = !bus_reg.rvalid;
	assign s_axi_bvalid = bus_reg.bvalid;
	assign s_axi_bresp = bus_reg.bresp;
	assign s_axi_rvalid = bus_reg.rvalid;
	assign s_axi_rdata = bus_reg.rdata;
	assign s_axi_rresp = bus_reg.rresp;
	assign reg_wr_en = bus_reg.aw_have && bus_reg.w_have && !bus_reg.bvalid;
	assign reg_wr_addr = bus_reg.awaddr;
	assign reg_wr_data = bus_reg.wdata;
	assign reg_wr_strb = bus_reg.wstrb;
	assign reg_rd_addr = s_axi_araddr;

	always_comb
	begin
		bus_next = bus_reg;
		if (bus_reg.bvalid && s_axi_bready)
			bus_next.bvalid = 1'b0;
		if (bus_reg.rvalid && s_axi_rready)
			bus_next.rvalid = 1'b0;
		if (s_axi_awvalid && s_axi_awready)
		begin
			bus_next.aw_have = 1'b1;
			bus_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			bus_next.w_have = 1'b1;
			bus_next.wdata = s_axi_wdata;
			bus_next.wstrb = s_axi_wstrb;
		end
		// both halves held: commit and answer next cycle
		if (reg_wr_en)
		begin
			bus_next.aw_have = 1'b0;
			bus_next.w_have = 1'b0;
			bus_next.bvalid = 1'b1;
			bus_next.bresp = reg_wr_ok ? `RMDE_RESP_OKAY : `RMDE_RESP_SLVERR;
		end
		if (s_axi_arvalid && s_axi_arready)
		begin
			bus_next.rvalid = 1'b1;
			bus_next.rdata = reg_rd_data;
			bus_next.rresp = reg_rd_ok ? `RMDE_RESP_OKAY : `RMDE_RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			bus_reg <= '0;
		else
			bus_reg <= bus_next;
	end
endmodule

// ==== rtl/rmde_top.sv ====
// register move decode and execute unit, driven over axi4-lite
// assumes register files and coprocessors answer reads one cycle late
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "rmde_cfg.svh"
module rmde_top
	import rmde_pkg::*;
#(
	parameter int CC_COUNT = 8
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// general register file
	output logic [4:0] greg_raddr_a,
	output logic [4:0] greg_raddr_b,
	input wire logic [31:0] greg_rdata_a,
	input wire logic [31:0] greg_rdata_b,
	output logic greg_we,
	output logic [4:0] greg_waddr,
	output logic [31:0] greg_wdata,
	// fp register file
	output logic [4:0] freg_raddr_a,
	output logic [4:0] freg_raddr_b,
	input wire logic [63:0] freg_rdata_a,
	input wire logic [63:0] freg_rdata_b,
	output logic freg_we,
	output logic [4:0] freg_waddr,
	output logic [63:0] freg_wdata,
	input wire logic [CC_COUNT-1:0] fp_cond_codes,
	// system coprocessor
	output logic [4:0] cp0_raddr,
	output logic [2:0] cp0_bank_index,
	input wire logic [63:0] cp0_rdata,
	input wire logic cp0_ext_ok,
	// coprocessor two
	output logic [15:0] coproc_two_major_opcode_reg_specifier,
	input wire logic [63:0] cp2_rdata,
	input wire logic cp2_wide_ok,
	// product registers
	input wire logic [31:0] upper_product_register,
	input wire logic [31:0] bottom_product_word,
	// exception report
	output logic exc_valid,
	output logic [1:0] exc_code
);
	rmde_core_type core_reg;
	rmde_core_type core_next;
	rmde_dec_type dec;
	logic reg_wr_en;
	logic [7:0] reg_wr_addr;
	logic [31:0] reg_wr_data;
	logic [3:0] reg_wr_strb;
	logic reg_wr_ok;
	logic [7:0] reg_rd_addr;
	logic [31:0] reg_rd_data;
	logic reg_rd_ok;
	logic [31:0] status_word;
	logic op_fp;
	logic op_cp2;
	logic op_high_new;
	logic reserved_trap;
	logic unusable_trap;
	logic pair_fmt;
	logic pair_ok;
	logic cc_lower;
	logic cc_upper;
	logic [2:0] cc_next;

	function automatic logic [31:0] rmde_merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] strb);
		logic [31:0] res;
		res = old_w;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				res[i*8 +: 8] = new_w[i*8 +: 8];
		return res;
	endfunction

	rmde_axil u_axil
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.reg_wr_en(reg_wr_en),
		.reg_wr_addr(reg_wr_addr),
		.reg_wr_data(reg_wr_data),
		.reg_wr_strb(reg_wr_strb),
		.reg_wr_ok(reg_wr_ok),
		.reg_rd_addr(reg_rd_addr),
		.reg_rd_data(reg_rd_data),
		.reg_rd_ok(reg_rd_ok)
	);

	rmde_decode u_decode
	(
		.instr(core_reg.instr),
		.dec(dec)
	);

	// read ports follow the held instruction
	assign greg_raddr_a = dec.src_a;
	assign greg_raddr_b = dec.src_b;
	assign freg_raddr_a = dec.src_a;
	assign freg_raddr_b = dec.src_b;
	assign cp0_raddr = dec.cp_sel[`RMDE_F_CPRD];
	assign cp0_bank_index = dec.cp_sel[`RMDE_F_SEL];
	assign coproc_two_major_opcode_reg_specifier = dec.cp_sel;

	assign greg_we = core_reg.greg_we;
	assign greg_waddr = core_reg.greg_waddr;
	assign greg_wdata = core_reg.greg_wdata;
	assign freg_we = core_reg.freg_we;
	assign freg_waddr = core_reg.freg_waddr;
	assign freg_wdata = core_reg.freg_wdata;
	assign exc_valid = core_reg.exc_pulse;
	assign exc_code = core_reg.exc_code;

	assign op_fp = dec.op == RMDE_OP_FREG_HIGH || dec.op == RMDE_OP_FCOPY ||
		dec.op == RMDE_OP_FCMOVF || dec.op == RMDE_OP_GCMOVF;
	assign op_cp2 = dec.op == RMDE_OP_CP2_WORD || dec.op == RMDE_OP_CP2_HIGH;
	assign op_high_new = dec.op == RMDE_OP_FREG_HIGH ||
		dec.op == RMDE_OP_CP2_HIGH;
	assign reserved_trap = dec.op == RMDE_OP_BAD ||
		(op_high_new && core_reg.ctrl[`RMDE_CTRL_REL] < `RMDE_REL2);
	assign unusable_trap =
		(dec.op == RMDE_OP_SYS_HIGH && !core_reg.ctrl[`RMDE_CTRL_CU0]) ||
		(op_fp && !core_reg.ctrl[`RMDE_CTRL_CU1]) ||
		(op_cp2 && !core_reg.ctrl[`RMDE_CTRL_CU2]);
	assign pair_fmt = dec.fmt == `RMDE_FMT_PAIR;
	assign pair_ok = core_reg.ctrl[`RMDE_CTRL_WIDE_MODE] &&
		core_reg.ctrl[`RMDE_CTRL_FPU64];
	assign cc_next = dec.cond + 3'h1;
	assign cc_lower = fp_cond_codes[dec.cond];
	assign cc_upper = fp_cond_codes[cc_next];

	always_comb
	begin
		status_word = '0;
		status_word[`RMDE_ST_BUSY] = core_reg.state != RMDE_IDLE;
		status_word[`RMDE_ST_DONE] = core_reg.done;
		status_word[`RMDE_ST_EXC] = core_reg.exc_flag;
		status_word[`RMDE_ST_CODE] = core_reg.exc_code;
		status_word[`RMDE_ST_UNDEF] = core_reg.undef;
		status_word[`RMDE_ST_WROTE] = core_reg.wrote;
	end

	// unmapped reads answer slverr with zero data
	always_comb
	begin
		reg_rd_data = '0;
		reg_rd_ok = 1'b1;
		unique case (reg_rd_addr)
			`RMDE_OFF_CTRL: reg_rd_data = core_reg.ctrl;
			`RMDE_OFF_INSTR: reg_rd_data = core_reg.instr;
			`RMDE_OFF_STATUS: reg_rd_data = status_word;
			`RMDE_OFF_RES_LOWER: reg_rd_data = core_reg.res_lower;
			`RMDE_OFF_RES_UPPER: reg_rd_data = core_reg.res_upper;
			default: reg_rd_ok = 1'b0;
		endcase
	end

	assign reg_wr_ok = reg_wr_addr == `RMDE_OFF_CTRL ||
		reg_wr_addr == `RMDE_OFF_INSTR || reg_wr_addr == `RMDE_OFF_STATUS ||
		reg_wr_addr == `RMDE_OFF_RES_LOWER || reg_wr_addr == `RMDE_OFF_RES_UPPER;

	always_comb
	begin
		core_next = core_reg;
		core_next.greg_we = 1'b0;
		core_next.freg_we = 1'b0;
		core_next.exc_pulse = 1'b0;
		if (reg_wr_en && reg_wr_addr == `RMDE_OFF_CTRL)
			core_next.ctrl = rmde_merge(core_reg.ctrl, reg_wr_data, reg_wr_strb);
		// sticky bits clear on writing ones; a set below wins
		if (reg_wr_en && reg_wr_addr == `RMDE_OFF_STATUS && reg_wr_strb[0])
		begin
			if (reg_wr_data[`RMDE_ST_DONE])
				core_next.done = 1'b0;
			if (reg_wr_data[`RMDE_ST_EXC])
				core_next.exc_flag = 1'b0;
			if (reg_wr_data[`RMDE_ST_UNDEF])
				core_next.undef = 1'b0;
			if (reg_wr_data[`RMDE_ST_WROTE])
				core_next.wrote = 1'b0;
		end
		unique case (core_reg.state)
			RMDE_IDLE:
			begin
				// a launch while busy is dropped, the bus still answers okay
				if (reg_wr_en && reg_wr_addr == `RMDE_OFF_INSTR)
				begin
					core_next.instr = rmde_merge(core_reg.instr, reg_wr_data,
						reg_wr_strb);
					core_next.done = 1'b0;
					core_next.exc_flag = 1'b0;
					core_next.exc_code = RMDE_EXC_NONE;
					core_next.undef = 1'b0;
					core_next.wrote = 1'b0;
					core_next.state = RMDE_READ;
				end
			end
			RMDE_READ:
			begin
				core_next.state = RMDE_EXEC;
			end
			RMDE_EXEC:
			begin
				core_next.state = RMDE_IDLE;
				core_next.done = 1'b1;
				core_next.greg_waddr = dec.dst;
				core_next.freg_waddr = dec.dst;
				if (reserved_trap || unusable_trap)
				begin
					core_next.exc_flag = 1'b1;
					core_next.exc_pulse = 1'b1;
					core_next.exc_code = reserved_trap ? RMDE_EXC_RI : RMDE_EXC_CPU;
				end
				else
				begin
					core_next.exc_code = RMDE_EXC_NONE;
					core_next.greg_we = 1'b1;
					unique case (dec.op)
						RMDE_OP_CP2_WORD:
						begin
							core_next.greg_wdata = cp2_rdata[31:0];
						end
						RMDE_OP_SYS_HIGH:
						begin
							core_next.greg_wdata = cp0_rdata[63:32];
							core_next.undef = !cp0_ext_ok;
						end
						RMDE_OP_FREG_HIGH:
						begin
							core_next.greg_wdata = freg_rdata_a[63:32];
							core_next.undef = !core_reg.ctrl[`RMDE_CTRL_WIDE_MODE] &&
								dec.src_a[0];
						end
						RMDE_OP_CP2_HIGH:
						begin
							core_next.greg_wdata = cp2_rdata[63:32];
							core_next.undef = !cp2_wide_ok;
						end
						RMDE_OP_UPPER:
						begin
							// live product value, no interlock needed
							core_next.greg_wdata = upper_product_register;
						end
						RMDE_OP_BOTTOM:
						begin
							core_next.greg_wdata = bottom_product_word;
						end
						RMDE_OP_GCMOVF:
						begin
							core_next.greg_we = !cc_lower;
							core_next.greg_wdata = greg_rdata_a;
						end
						RMDE_OP_NZ:
						begin
							core_next.greg_we = greg_rdata_b != '0;
							core_next.greg_wdata = greg_rdata_a;
						end
						RMDE_OP_FCOPY:
						begin
							core_next.greg_we = 1'b0;
							core_next.freg_we = 1'b1;
							core_next.freg_wdata = freg_rdata_a;
							core_next.undef = pair_fmt && !pair_ok;
						end
						RMDE_OP_FCMOVF:
						begin
							core_next.greg_we = 1'b0;
							// plain copy, no fp cause raised
							core_next.freg_we = pair_fmt || !cc_lower;
							if (pair_fmt)
							begin
								core_next.freg_wdata = {
									cc_upper ? freg_rdata_b[63:32] : freg_rdata_a[63:32],
									cc_lower ? freg_rdata_b[31:0] : freg_rdata_a[31:0]};
								core_next.undef = dec.cond[0] || !pair_ok;
							end
							else
							begin
								core_next.freg_wdata = freg_rdata_a;
							end
						end
						default:
						begin
							core_next.greg_we = 1'b0;
						end
					endcase
					core_next.wrote = core_next.greg_we || core_next.freg_we;
					if (core_next.freg_we)
					begin
						core_next.res_lower = core_next.freg_wdata[31:0];
						core_next.res_upper = core_next.freg_wdata[63:32];
					end
					else if (core_next.greg_we)
					begin
						core_next.res_lower = core_next.greg_wdata;
						core_next.res_upper = '0;
					end
				end
			end
			default:
			begin
				core_next.state = RMDE_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			core_reg <= '0;
			core_reg.ctrl <= `RMDE_CTRL_RST;
		end
		else
			core_reg <= core_next;
	end
endmodule

// ==== tb/rmde_far_model.sv ====
// far side: register files and coprocessors as fixed patterns
// assumes the unit samples read data one cycle after the address
`timescale 1ns/1ps
module rmde_far_model
(
	// clock
	input wire logic aclk,
	// read addresses
	input wire logic [4:0] greg_raddr_a,
	input wire logic [4:0] greg_raddr_b,
	input wire logic [4:0] freg_raddr_a,
	input wire logic [4:0] freg_raddr_b,
	input wire logic [4:0] cp0_raddr,
	input wire logic [2:0] cp0_bank_index,
	input wire logic [15:0] coproc_two_major_opcode_reg_specifier,
	// read data
	output logic [31:0] greg_rdata_a,
	output logic [31:0] greg_rdata_b,
	output logic [63:0] freg_rdata_a,
	output logic [63:0] freg_rdata_b,
	output logic [63:0] cp0_rdata,
	output logic [63:0] cp2_rdata
);
	// register zero reads zero so the nonzero test sees both outcomes
	function automatic logic [31:0] gv(input logic [4:0] a);
		return (a == 5'h00) ? 32'h0 : {4'ha, 23'h0, a};
	endfunction
	always @(posedge aclk)
	begin
		greg_rdata_a <= gv(greg_raddr_a);
		greg_rdata_b <= gv(greg_raddr_b);
		freg_rdata_a <= {8'h11, 19'h0, freg_raddr_a, 8'h22, 19'h0, freg_raddr_a};
		freg_rdata_b <= {8'h11, 19'h0, freg_raddr_b, 8'h22, 19'h0, freg_raddr_b};
		// every register banked, any index legal
		cp0_rdata <= {8'hc0, 16'h0, cp0_bank_index, cp0_raddr, 32'h0};
		cp2_rdata <= {coproc_two_major_opcode_reg_specifier, 16'hcafe, 16'h0, coproc_two_major_opcode_reg_specifier};
	end
endmodule

// ==== tb/rmde_props.sv ====
// checker of the move unit, sees only the top ports
// assumes one clock and the synchronous active low reset
`timescale 1ns/1ps
module rmde_props
#(
	parameter int CC_COUNT = 8
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// results
	input wire logic greg_we,
	input wire logic freg_we,
	input wire logic exc_valid,
	input wire logic [1:0] exc_code
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_greg_pulse: assert property (greg_we |=> !greg_we)
		else $error("greg write too long");
	a_freg_pulse: assert property (freg_we |=> !freg_we)
		else $error("freg write too long");
	a_exc_pulse: assert property (exc_valid |=> !exc_valid)
		else $error("exception too long");
	a_exc_no_write: assert property (exc_valid |-> !greg_we && !freg_we)
		else $error("write with exception");
	a_exc_then_quiet: assert property (exc_valid |=>
		(!greg_we && !freg_we)[*2]) else $error("write after exception");
	a_exc_coded: assert property (exc_valid |-> exc_code != 2'h0)
		else $error("exception without code");
	a_one_dest: assert property (!(greg_we && freg_we))
		else $error("two writes at once");
	a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("aw ready with response");
	a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("ar ready with read data");
endmodule
bind rmde_top rmde_props #(.CC_COUNT(CC_COUNT)) props (.aclk, .aresetn,
	.s_axi_awready, .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid,
	.greg_we, .freg_we, .exc_valid, .exc_code);

// ==== tb/tb_top.sv ====
// bench: axi4-lite master, far model, random move instructions
// assumes results pulse three cycles after the instruction commit
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
	failures++; $display("BAD %s exp %h got %h", n, e, s); end end
module tb_top;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, greg_we, freg_we;
	logic exc_valid, cp0_ext_ok, cp2_wide_ok;
	logic [7:0] s_axi_awaddr, s_axi_araddr, fp_cond_codes;
	logic [31:0] s_axi_wdata, s_axi_rdata, greg_rdata_a, greg_rdata_b;
	logic [31:0] greg_wdata, upper_product_register, bottom_product_word;
	logic [63:0] freg_rdata_a, freg_rdata_b, freg_wdata, cp0_rdata;
	logic [63:0] cp2_rdata;
	logic [4:0] greg_raddr_a, greg_raddr_b, greg_waddr, freg_raddr_a;
	logic [4:0] freg_raddr_b, freg_waddr, cp0_raddr;
	logic [3:0] s_axi_wstrb;
	logic [2:0] cp0_bank_index;
	logic [15:0] coproc_two_major_opcode_reg_specifier;
	logic [1:0] s_axi_bresp, s_axi_rresp, exc_code, rsp, seen_exc;
	logic [31:0] rd_v, ins;
	logic [70:0] seen, want;
	int failures, total_checks, seed, i;
	rmde_top #(.CC_COUNT(8)) uut (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.greg_raddr_a, .greg_raddr_b, .greg_rdata_a, .greg_rdata_b,
		.greg_we, .greg_waddr, .greg_wdata, .freg_raddr_a, .freg_raddr_b,
		.freg_rdata_a, .freg_rdata_b, .freg_we, .freg_waddr, .freg_wdata,
		.fp_cond_codes, .cp0_raddr, .cp0_bank_index, .cp0_rdata,
		.cp0_ext_ok, .coproc_two_major_opcode_reg_specifier, .cp2_rdata, .cp2_wide_ok,
		.upper_product_register, .bottom_product_word, .exc_valid,
		.exc_code);
	rmde_far_model far (.aclk, .greg_raddr_a, .greg_raddr_b,
		.freg_raddr_a, .freg_raddr_b, .cp0_raddr, .cp0_bank_index,
		.coproc_two_major_opcode_reg_specifier, .greg_rdata_a, .greg_rdata_b, .freg_rdata_a,
		.freg_rdata_b, .cp0_rdata, .cp2_rdata);
	function automatic logic [31:0] gv(input logic [4:0] a);
		return (a == 5'h00) ? 32'h0 : {4'ha, 23'h0, a};
	endfunction
	function automatic logic [63:0] fv(input logic [4:0] a);
		return {8'h11, 19'h0, a, 8'h22, 19'h0, a};
	endfunction
	task automatic stop_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// the loop test lags the handshakes by one edge, costing one idle cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		// raised valids only land after the edge, so test at the bottom
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
			begin
				rsp = s_axi_bresp;
				s_axi_bready <= 1'b0;
			end
		end
		while (s_axi_awvalid | s_axi_wvalid | s_axi_bready);
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
			begin
				{rd_v, rsp} = {s_axi_rdata, s_axi_rresp};
				s_axi_rready <= 1'b0;
			end
		end
		while (s_axi_rready);
	endtask
	task automatic one(input int k, input logic [1:0] e);
		logic [31:0] r, up, bt;
		logic [4:0] x, y, z;
		logic [2:0] c;
		logic [7:0] cc;
		logic [63:0] fs, fd;
		logic [31:0] sw;
		r = $random(seed);
		{up, bt, cc} = {$random(seed), $random(seed), r[27:20]};
		{x, y, z, c} = {r[4:0], r[9:5], r[14:10], r[17:16], r[18] & k != 9};
		{fs, fd} = {fv(y), fv(z)};
		upper_product_register <= up;
		bottom_product_word <= bt;
		fp_cond_codes <= cc;
		{cp0_ext_ok, cp2_wide_ok} <= r[29:28];
		case (k)
			0: {ins, want} = {6'h00, 10'h0, x, 11'h10, 2'h1, x, 32'h0, up};
			1: {ins, want} = {6'h00, 10'h0, x, 11'h12, 2'h1, x, 32'h0, bt};
			2: {ins, want} = {6'h12, 5'h00, x, r[31:16], 2'h1, x, 48'h0, r[31:16]};
			3: {ins, want} = {6'h10, 5'h02, x, y, 8'h0, c, 2'h1, x, 32'h0,
				8'hc0, 16'h0, c, y};
			4: {ins, want} = {6'h11, 5'h03, x, y, 11'h0, 2'h1, x, 32'h0, fs[63:32]};
			5: {ins, want} = {6'h12, 5'h03, x, r[31:16], 2'h1, x, 32'h0,
				r[31:16], 16'hcafe};
			6: {ins, want} = {6'h00, y, c, 2'h0, x, 11'h01, cc[c] ? 71'h0 :
				{2'h1, x, 32'h0, gv(y)}};
			7: {ins, want} = {6'h11, 10'h220, y, z, 6'h06, 2'h2, z, fs};
			8: {ins, want} = {6'h11, 5'h11, c, 2'h0, y, z, 6'h11, cc[c] ? 71'h0 :
				{2'h2, z, fs}};
			9: {ins, want} = {6'h11, 5'h16, c, 2'h0, y, z, 6'h11, 2'h2, z,
				cc[c + 3'h1] ? fd[63:32] : fs[63:32], cc[c] ? fd[31:0] : fs[31:0]};
			default: {ins, want} = {6'h00, y, z, x, 11'h0b, gv(z) == 32'h0 ?
				71'h0 : {2'h1, x, 32'h0, gv(y)}};
		endcase
		if (e != 2'h0) want = 71'h0;
		seen <= 71'h0;
		seen_exc <= 2'h0;
		wr(8'h04, ins);
		repeat (4) @(posedge aclk);
		`CHK("result", want, seen)
		`CHK("exception", e, seen_exc)
		// status: wrote, undefined, code, exception, done, not busy
		sw = {25'h0, want != 71'h0, (k == 3 && !r[29]) ||
			(k == 5 && e == 2'h0 && !r[28]), e, e != 2'h0, 2'h2};
		rd(8'h08);
		`CHK("status", sw, rd_v)
		$display("op %0d done", k);
	endtask
	always @(posedge aclk)
	begin
		if (greg_we === 1'b1) seen <= {2'h1, greg_waddr, 32'h0, greg_wdata};
		if (freg_we === 1'b1) seen <= {2'h2, freg_waddr, freg_wdata};
		if (exc_valid === 1'b1) seen_exc <= exc_code;
	end
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	initial
	begin
		#2000000;
		failures++;
		stop_test();
	end
	initial
	begin
		{seed, failures, total_checks} = {32'h1edbe350, 64'h0};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
		{s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 49'h0;
		{fp_cond_codes, cp0_ext_ok, cp2_wide_ok} = 10'h0;
		{upper_product_register, bottom_product_word} = 64'h0;
		s_axi_wstrb = 4'hf;
		aresetn = 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(8'h00);
		`CHK("ctrl reset", 32'h0000021c, rd_v)
		rd(8'h40);
		`CHK("unmapped resp", 2'h2, rsp)
		wr(8'h40, 32'h0);
		`CHK("unmapped write resp", 2'h2, rsp)
		// wide mode and 64-bit unit so paired results are defined
		wr(8'h00, 32'h0000021f);
		`CHK("ctrl write resp", 2'h0, rsp)
		for (i = 0; i < 110; i++) one(i % 11, 2'h0);
		wr(8'h00, 32'h0000011f);
		one(4, 2'h1);
		one(5, 2'h1);
		wr(8'h00, 32'h00000217);
		one(7, 2'h2);
		stop_test();
	end
endmodule
